// File: logic/ovs_irq_pkg.sv
// Constants, register map and types for the oversampling and irq divider
package ovs_irq_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_PERIOD = 8'h04;
    localparam logic [7:0] REG_SAMPLE = 8'h08;
    localparam logic [7:0] REG_IDIV   = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_MASK   = 8'h14;
    localparam logic [7:0] REG_COUNT  = 8'h18;

    // Control register fields
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_OVS_LSB = 1;
    localparam int OVS_W        = 2;
    localparam int IDIV_W       = 4;
    localparam int DCNT_W       = 8;

    // Status and mask bit positions
    localparam int ST_W          = 2;
    localparam int ST_PERIOD_IRQ = 0;
    localparam int ST_SAMPLE     = 1;

    // Reset values
    localparam logic [OVS_W-1:0]  OVS_RST  = 2'h0;
    localparam logic [IDIV_W-1:0] IDIV_RST = 4'h0;
    localparam logic [ST_W-1:0]   MASK_RST = 2'h0;
    localparam logic [DCNT_W-1:0] DCNT_RST = 8'h00;

    // Oversampling codes
    localparam logic [OVS_W-1:0] OVS_X1 = 2'h0;
    localparam logic [OVS_W-1:0] OVS_X2 = 2'h1;
    localparam logic [OVS_W-1:0] OVS_X4 = 2'h2;
    localparam logic [OVS_W-1:0] OVS_X8 = 2'h3;

    // Divide setting that leaves the period interrupt off
    localparam logic [IDIV_W-1:0] IDIV_OFF = 4'h0;

    typedef enum logic [1:0] {
        OS_IDLE = 2'b01,
        OS_RUN  = 2'b10
    } os_state_t;

endpackage : ovs_irq_pkg

// File: logic/pwm_oversample_irq_divider.sv
// Sample-trigger oversampling and period interrupt divider of one channel
// Operation
// - With oversampling code 00 one error_adc trigger fires per period where the counter equals the sample value.
// - Codes 01, 10 and 11 give two, four and eight error_adc triggers per period.
// - Extra triggers follow the first at spacing of the period divided by 2, 4 or 8.
// - The cpu interrupt event is derived from the period and fires at most once per divided group of periods.
// - The divider count reaches up to 255 and the event comes every count plus one periods.
// - Divide settings 1 to 15 map to counts 0,1,3,7,15,31,47,63,79,95,127,159,191,223,255.
// - The divided event also starts the general_adc conversion sequence.
// - The period register holds the period count and the counter restarts on reaching it.
`timescale 1ns/10ps
module pwm_oversample_irq_divider
#(
    parameter int CNT_W = 14
) (
    input  wire logic              CLK,
    input  wire logic              SRST,
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    input  wire logic              WB_WE_I,
    input  wire logic [7:0]        WB_ADR_I,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic      [31:0]       WB_DAT_O,
    output logic                   WB_ACK_O,
    output logic                   ERROR_ADC_TRIG,
    output logic                   GENERAL_ADC_TRIG,
    output logic                   IRQ
);
    import ovs_irq_pkg::*;

    if (CNT_W < 4 || CNT_W > 24) begin : g_chk
        $error("CNT_W must lie between 4 and 24");
    end

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Divide setting to divider count
    function automatic logic [DCNT_W-1:0] div_count(
        input logic [IDIV_W-1:0] s);
        logic [DCNT_W-1:0] c;
        c = 8'h00;
        unique case (s)
            4'h1:    c = 8'h00;
            4'h2:    c = 8'h01;
            4'h3:    c = 8'h03;
            4'h4:    c = 8'h07;
            4'h5:    c = 8'h0F;
            4'h6:    c = 8'h1F;
            4'h7:    c = 8'h2F;
            4'h8:    c = 8'h3F;
            4'h9:    c = 8'h4F;
            4'hA:    c = 8'h5F;
            4'hB:    c = 8'h7F;
            4'hC:    c = 8'h9F;
            4'hD:    c = 8'hBF;
            4'hE:    c = 8'hDF;
            4'hF:    c = 8'hFF;
            default: c = 8'h00;
        endcase
        return c;
    endfunction : div_count

    logic                ack_q;
    logic                en_q;
    logic [OVS_W-1:0]    ovs_q;
    logic [CNT_W-1:0]    period_q;
    logic [CNT_W-1:0]    sample_q;
    logic [IDIV_W-1:0]   idiv_q;
    logic [ST_W-1:0]     status_q;
    logic [ST_W-1:0]     mask_q;
    logic [CNT_W-1:0]    cnt_q;
    logic [DCNT_W-1:0]   div_cnt_q;
    os_state_t           state_q;
    logic [CNT_W:0]      sub_q;
    logic [2:0]          left_q;
    logic [31:0]         rdata;
    logic                req;
    logic                wr;
    logic [31:0]         wval;
    logic                period_end;
    logic                hit;
    logic                fire;
    logic                irq_evt;
    logic                idiv_wr;
    logic [CNT_W:0]      ival;
    logic [2:0]          extras;

    // Bus access; ack comes one cycle after the request is seen
    assign req     = WB_CYC_I && WB_STB_I;
    assign wr      = req && WB_WE_I && ack_q;
    assign idiv_wr = wr && WB_ADR_I == REG_IDIV && WB_SEL_I[0];
    assign WB_ACK_O = ack_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (WB_ADR_I)
            REG_CTRL: begin
                rdata[CTRL_EN_BIT] = en_q;
                rdata[CTRL_OVS_LSB +: OVS_W] = ovs_q;
            end
            REG_PERIOD: rdata[CNT_W-1:0]  = period_q;
            REG_SAMPLE: rdata[CNT_W-1:0]  = sample_q;
            REG_IDIV:   rdata[IDIV_W-1:0] = idiv_q;
            REG_STATUS: rdata[ST_W-1:0]   = status_q;
            REG_MASK:   rdata[ST_W-1:0]   = mask_q;
            REG_COUNT:  rdata[CNT_W-1:0]  = cnt_q;
            default:    rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (req && !ack_q && !WB_WE_I) begin
            WB_DAT_O <= rdata;
        end
    end

    assign wval = merge(rdata, WB_DAT_I, WB_SEL_I);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            en_q     <= 1'b0;
            ovs_q    <= OVS_RST;
            period_q <= '0;
            sample_q <= '0;
            idiv_q   <= IDIV_RST;
            mask_q   <= MASK_RST;
        end else if (wr) begin
            unique case (WB_ADR_I)
                REG_CTRL: begin
                    en_q  <= wval[CTRL_EN_BIT];
                    ovs_q <= wval[CTRL_OVS_LSB +: OVS_W];
                end
                REG_PERIOD: period_q <= wval[CNT_W-1:0];
                REG_SAMPLE: sample_q <= wval[CNT_W-1:0];
                REG_IDIV:   idiv_q   <= wval[IDIV_W-1:0];
                REG_MASK:   mask_q   <= wval[ST_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Period counter; >= guards a period shortened below the count
    assign period_end = en_q && cnt_q >= period_q;
    assign hit        = en_q && cnt_q == sample_q;

    always_ff @(posedge CLK) begin
        if (SRST || !en_q) begin
            cnt_q <= '0;
        end else if (period_end) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Oversampling: spacing is the period length shifted by the code
    assign ival   = ({1'b0, period_q} + 1'b1) >> ovs_q;
    assign extras = 3'((4'h1 << ovs_q) - 4'h1);
    assign fire   = en_q && state_q == OS_RUN && sub_q == ival;

    always_ff @(posedge CLK) begin
        if (SRST || !en_q) begin
            state_q <= OS_IDLE;
            sub_q   <= '0;
            left_q  <= 3'h0;
        end else begin
            unique case (state_q)
                OS_IDLE: begin
                    if (hit && ovs_q != OVS_X1 && ival != '0) begin
                        state_q <= OS_RUN;
                        sub_q   <= (CNT_W+1)'(1);
                        left_q  <= extras;
                    end
                end
                OS_RUN: begin
                    if (fire) begin
                        sub_q  <= (CNT_W+1)'(1);
                        left_q <= left_q - 3'h1;
                        if (left_q == 3'h1) begin
                            state_q <= OS_IDLE;
                        end
                    end else begin
                        sub_q <= sub_q + 1'b1;
                    end
                end
                default: state_q <= OS_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ERROR_ADC_TRIG <= 1'b0;
        end else begin
            ERROR_ADC_TRIG <= hit || fire;
        end
    end

    // Period interrupt divider; setting 0 keeps it silent
    assign irq_evt = period_end && idiv_q != IDIV_OFF
                     && div_cnt_q == div_count(idiv_q);

    always_ff @(posedge CLK) begin
        if (SRST || idiv_wr) begin
            div_cnt_q <= DCNT_RST;
        end else if (irq_evt) begin
            div_cnt_q <= DCNT_RST;
        end else if (period_end && idiv_q != IDIV_OFF) begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            GENERAL_ADC_TRIG <= 1'b0;
        end else begin
            GENERAL_ADC_TRIG <= irq_evt;
        end
    end

    // Sticky status; a new event beats a simultaneous clear
    always_ff @(posedge CLK) begin
        if (SRST) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q
                & ~((wr && WB_ADR_I == REG_STATUS && WB_SEL_I[0])
                    ? WB_DAT_I[ST_W-1:0] : '0))
                | {hit || fire, irq_evt};
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status_q & mask_q);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_hit_x1;
        hit && ovs_q == OVS_X1 && state_q == OS_IDLE;
    endsequence

    sequence s_start_ovs;
        hit && state_q == OS_IDLE && ovs_q != OVS_X1 && ival > 1;
    endsequence

    a_single_trig: assert property (
        s_hit_x1 |=> ERROR_ADC_TRIG ##1 !ERROR_ADC_TRIG)
        else $error("sample hit did not give one trigger");

    a_no_stray: assert property (
        (state_q == OS_IDLE && !hit) |=> !ERROR_ADC_TRIG)
        else $error("trigger without a sample hit");

    a_ovs_start: assert property (
        s_start_ovs |=> state_q == OS_RUN
            && left_q == ($past(ovs_q) == OVS_X2 ? 3'h1
                          : $past(ovs_q) == OVS_X4 ? 3'h3 : 3'h7))
        else $error("oversampling did not start");

    a_ovs_spacing: assert property (
        (state_q == OS_RUN && en_q && sub_q == ival) |=> ERROR_ADC_TRIG)
        else $error("extra trigger missing at interval");

    a_period_wrap: assert property (
        (period_end && !$rose(en_q)) |=> cnt_q == '0)
        else $error("counter did not restart at period");

    a_div_count: assert property (
        irq_evt |-> div_cnt_q == div_count(idiv_q))
        else $error("interrupt at wrong divider count");

    a_div_range: assert property (
        div_cnt_q <= div_count(idiv_q) || idiv_q == IDIV_OFF
        || $past(idiv_wr) || $changed(idiv_q))
        else $error("divider ran past its count");

    a_irq_once: assert property (
        (irq_evt && period_q != '0) |=> !irq_evt)
        else $error("two interrupts within one period");

    a_adc_follow: assert property (
        irq_evt |=> GENERAL_ADC_TRIG ##1 !GENERAL_ADC_TRIG || irq_evt)
        else $error("general adc trigger not tied to interrupt");

    a_div_clear: assert property (
        idiv_wr |=> div_cnt_q == DCNT_RST)
        else $error("divider not cleared on setting write");

    a_status_set: assert property (
        irq_evt |=> status_q[ST_PERIOD_IRQ] ##1
            (IRQ || !mask_q[ST_PERIOD_IRQ] || $past(wr)))
        else $error("status or irq output lost an event");

    a_bus_ack: assert property (
        (req && !ack_q) |=> ack_q ##1 !ack_q)
        else $error("bus ack not one cycle after request");

endmodule : pwm_oversample_irq_divider

// File: testbench/trig_sink_model.sv
// Sink model of the error_adc front end and general_adc start input
`timescale 1ns/10ps
module trig_sink_model (
    input  wire logic CLK,
    input  wire logic CLR,
    input  wire logic ERR_TRIG,
    input  wire logic GEN_TRIG,
    output int        ERR_N,
    output int        ERR_GAP,
    output int        GEN_N,
    output int        GEN_GAP,
    output int        GEN_FIRST
);
    int t_q;
    int err_t_q;
    int gen_t_q;
    // Time since the last clear, so gaps need no shared time base
    always_ff @(posedge CLK) begin
        t_q <= CLR ? 0 : t_q + 1;
    end
    always_ff @(posedge CLK) begin
        if (CLR) ERR_N <= 0;
        else if (ERR_TRIG === 1'h1) begin
            ERR_N   <= ERR_N + 1;
            ERR_GAP <= t_q - err_t_q;
            err_t_q <= t_q;
        end
    end
    always_ff @(posedge CLK) begin
        if (CLR) GEN_N <= 0;
        else if (GEN_TRIG === 1'h1) begin
            GEN_N   <= GEN_N + 1;
            GEN_GAP <= t_q - gen_t_q;
            gen_t_q <= t_q;
            if (GEN_N == 0) GEN_FIRST <= t_q;
        end
    end
endmodule : trig_sink_model

// File: testbench/pwm_oversample_irq_divider_tb.sv
// Self-checking bench for the oversampling and interrupt divider
`timescale 1ns/10ps
module pwm_oversample_irq_divider_tb;
    import ovs_irq_pkg::*;
    logic        clk, srst, cyc, stb, we, clr, ack, et, gt, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    int          en, eg, gn, gg, gf, n_fail, n_checks, ticks;
    int          tab [15] = '{0, 1, 3, 7, 15, 31, 47, 63, 79, 95, 127, 159,
                              191, 223, 255};

    pwm_oversample_irq_divider i_dut (
        .CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .ERROR_ADC_TRIG(et),
        .GENERAL_ADC_TRIG(gt), .IRQ(irq));
    trig_sink_model i_sink (
        .CLK(clk), .CLR(clr), .ERR_TRIG(et), .GEN_TRIG(gt), .ERR_N(en),
        .ERR_GAP(eg), .GEN_N(gn), .GEN_GAP(gg), .GEN_FIRST(gf));

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // The whole divider test needs about 43k cycles
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 90000) begin
            n_fail++;
            results();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h", $time, msg, got);
        end
    endtask : check

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'h1);
        check(k, 2, "ack one cycle after request");
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we  <= 1'h0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e, string m);
        wb(a, 1'h0, 32'h0);
        check(q, e, m);
    endtask : rd

    task automatic pause(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : pause

    task automatic t_reset();
        logic [7:0] regs [8] = '{REG_CTRL, REG_PERIOD, REG_SAMPLE, REG_IDIV,
                                 REG_STATUS, REG_MASK, REG_COUNT, 8'h40};
        check({et, gt, irq}, 32'h0, "outputs after reset");
        wb(8'h40, 1'h1, 32'hFFFFFFFF);
        foreach (regs[i]) rd(regs[i], 32'h0, "reset or unmapped");
    endtask : t_reset

    task automatic t_ovs();
        wb(REG_PERIOD, 1'h1, 32'h0000000F);
        wb(REG_SAMPLE, 1'h1, 32'h00000002); // sample point at count 2
        rd(REG_PERIOD, 32'h0000000F, "period readback");
        for (int c = 0; c < 4; c++) begin
            wb(REG_CTRL, 1'h1, 32'h0);
            wb(REG_CTRL, 1'h1, 32'(c * 2 + 1));
            repeat (40) @(posedge clk);
            clr <= 1'h1;
            @(posedge clk);
            clr <= 1'h0;
            pause(64);
            check(en, 4 << c, "triggers in four periods");
            check(eg, 16 >> c, "trigger spacing");
        end
    endtask : t_ovs

    task automatic t_div();
        int c;
        int k;
        wb(REG_CTRL, 1'h1, 32'h1);
        for (int s = 1; s < 16; s++) begin
            c = tab[s-1];
            wb(REG_IDIV, 1'h1, 32'(s));
            clr <= 1'h1;
            @(posedge clk);
            clr <= 1'h0;
            #1;
            k = 0;
            while (gn < 2 && k < 40 * c + 80) begin
                @(posedge clk);
                k++;
            end
            #1;
            check(gg, 16 * (c + 1), "interrupt spacing");
            check(gf >= 16 * c && gf <= 16 * c + 15, 1, "first");
        end
    endtask : t_div

    task automatic t_irq();
        int k;
        check(irq, 1'h0, "irq while masked");
        rd(REG_STATUS, 32'h3, "status after events");
        wb(REG_IDIV, 1'h1, 32'h0);
        wb(REG_CTRL, 1'h1, 32'h0);
        wb(REG_STATUS, 1'h1, 32'h1);
        rd(REG_STATUS, 32'h2, "one bit cleared");
        wb(REG_MASK, 1'h1, 32'h3);
        pause(2);
        check(irq, 1'h1, "irq unmasked");
        wb(REG_MASK, 1'h1, 32'h1);
        pause(2);
        check(irq, 1'h0, "irq masked out");
        wb(REG_STATUS, 1'h1, 32'h2);
        wb(REG_IDIV, 1'h1, 32'h1);
        wb(REG_CTRL, 1'h1, 32'h1);
        k = 0;
        while (gt !== 1'h1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        pause(3);
        check(irq, 1'h1, "irq after event");
        // Reset in mid-run must drop the divide setting too
        @(posedge clk);
        srst <= 1'h1;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        rd(REG_IDIV, 32'h0, "divide after reset");
        check(irq, 1'h0, "irq after reset");
    endtask : t_irq

    task automatic results();
        if (n_fail == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    initial begin
        srst = 1'h1;
        {cyc, stb, we, clr} = 4'h0;
        adr = 8'h00;
        wdat = 32'h0;
        sel = 4'hF;
        repeat (3) @(posedge clk);
        srst <= 1'h0;
        t_reset();
        t_ovs();
        t_div();
        t_irq();
        results();
    end
endmodule : pwm_oversample_irq_divider_tb
